// ===== verilog/shared_bus_host_port.sv
// shared-bus host port: decodes address and data phases from an external host
// assumes host pins are asynchronous and pass two flip-flops; rom access request comes from on-chip logic
`timescale 1ns/1ps
`default_nettype none
module shared_bus_host_port
	import shared_bus_pkg::*;
(
	// clock and reset
	input  wire logic              SYS_CLK,
	input  wire logic              RST_B,
	// host pins
	input  wire logic              CHIP_SELECT_LOW,
	input  wire logic              CMD_TYPE,
	input  wire logic              READ_STROBE_LOW,
	input  wire logic              WRITE_STROBE_LOW,
	input  wire logic [BUS_W-1:0]  SHARED_BUS_LINES_IN,
	output logic      [BUS_W-1:0]  SHARED_BUS_LINES_OUT,
	output logic                   SHARED_BUS_LINES_OE,
	input  wire logic              BUS_WIDTH_STRAP_PIN,
	// core side
	input  wire logic [BUS_W-1:0]  READ_DATA,
	input  wire logic              ROM_ACCESS,
	output logic                   CONFIG_ROM_SELECT,
	output logic      [ADDR_W-1:0] REG_ADDR,
	output logic      [BE_W-1:0]   BYTE_LANE_ENABLE,
	output logic                   WIDE_MODE,
	output logic                   WRITE_PULSE,
	output logic                   READ_PULSE,
	output logic      [BUS_W-1:0]  WRITE_DATA
);
	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic [BUS_W+4:0] sync1;
	logic [BUS_W+4:0] sync2;
	logic [BUS_W+4:0] next_sync1;
	always_comb begin
		next_sync1 = {BUS_WIDTH_STRAP_PIN, CHIP_SELECT_LOW, CMD_TYPE, READ_STROBE_LOW, WRITE_STROBE_LOW,
			SHARED_BUS_LINES_IN};
	end
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			sync1 <= '1;
			sync2 <= '1;
		end else begin
			sync1 <= next_sync1;
			sync2 <= sync1;
		end
	end
	logic             s_strap;
	logic             s_cs_low;
	logic             s_cmd;
	logic             s_rd_low;
	logic             s_wr_low;
	logic [BUS_W-1:0] s_bus;
	assign {s_strap, s_cs_low, s_cmd, s_rd_low, s_wr_low, s_bus} = sync2;

	// ------------------------------------------------------------
	// width strap capture
	// ------------------------------------------------------------
	// the synchronisers leave reset at their idle ones, so the strap is taken
	// only once its own level has reached the second flip-flop
	logic [STRAP_LAG-1:0] strap_age;
	logic [STRAP_LAG-1:0] next_strap_age;
	logic                 strap_done;
	logic                 wide;
	logic                 next_wide;
	assign strap_done = strap_age[STRAP_LAG-1];
	always_comb begin
		next_strap_age = {strap_age[STRAP_LAG-2:0], 1'b1};
		next_wide      = strap_done ? wide : s_strap; // see R8
	end
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin // see R5
			strap_age <= '0;
			wide      <= 1'b1;
		end else begin
			strap_age <= next_strap_age;
			wide      <= next_wide;
		end
	end

	// ------------------------------------------------------------
	// lane fitting
	// ------------------------------------------------------------
	// 8-bit mode carries the low lane only; upper lines read back as zero
	function automatic logic [BUS_W-1:0] lane_fit(input logic is_wide, input logic [BUS_W-1:0] word);
		return is_wide ? word : {HI_ZERO, word[BYTE_W-1:0]};
	endfunction : lane_fit

	// ------------------------------------------------------------
	// phase decode
	// ------------------------------------------------------------
	logic wr_prev;
	logic rd_prev;
	logic wr_fall;
	logic rd_fall;
	logic selected;
	assign selected = ~s_cs_low & strap_done; // see R4
	assign wr_fall  = wr_prev & ~s_wr_low;
	assign rd_fall  = rd_prev & ~s_rd_low; // see R9

	logic [ADDR_W-1:0] next_addr;
	logic [BE_W-1:0]   next_be;
	logic [BUS_W-1:0]  next_wdata;
	logic [BUS_W-1:0]  next_rdout;
	logic              next_oe;
	logic              next_wp;
	logic              next_rp;
	always_comb begin
		next_addr  = REG_ADDR;
		next_be    = BYTE_LANE_ENABLE;
		next_wdata = WRITE_DATA;
		next_rdout = SHARED_BUS_LINES_OUT;
		next_oe    = selected & s_cmd == 1'b0 & ~s_rd_low;
		next_wp    = 1'b0;
		next_rp    = 1'b0;
		if (selected && wr_fall && s_cmd) begin // see R10
			if (wide) begin
				next_addr = {s_bus[ADDR_W-1:A16_LSB], A16_PAD}; // see R2
				next_be   = s_bus[BE_LSB +: BE_W]; // see R7
			end else begin
				next_addr = s_bus[ADDR_W-1:0]; // see R3
				next_be   = BE_RST;
			end
		end else if (selected && wr_fall) begin
			next_wp    = 1'b1;
			next_wdata = lane_fit(wide, s_bus); // see R1
		end else if (selected && rd_fall && !s_cmd) begin
			next_rp    = 1'b1;
			next_rdout = lane_fit(wide, READ_DATA); // see R1
		end
	end
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			wr_prev              <= 1'b1;
			rd_prev              <= 1'b1;
			REG_ADDR             <= ADDR_RST;
			BYTE_LANE_ENABLE     <= BE_RST;
			WRITE_DATA           <= DATA_RST;
			SHARED_BUS_LINES_OUT <= DATA_RST;
			SHARED_BUS_LINES_OE  <= 1'b0;
			WRITE_PULSE          <= 1'b0;
			READ_PULSE           <= 1'b0;
			CONFIG_ROM_SELECT    <= 1'b0;
			WIDE_MODE            <= 1'b1;
		end else begin
			wr_prev              <= s_wr_low;
			rd_prev              <= s_rd_low;
			REG_ADDR             <= next_addr;
			BYTE_LANE_ENABLE     <= next_be;
			WRITE_DATA           <= next_wdata;
			SHARED_BUS_LINES_OUT <= next_rdout;
			SHARED_BUS_LINES_OE  <= next_oe;
			WRITE_PULSE          <= next_wp;
			READ_PULSE           <= next_rp;
			CONFIG_ROM_SELECT    <= ROM_ACCESS; // see R6
			WIDE_MODE            <= wide;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_no_pulse_unselected;
		@(posedge SYS_CLK) disable iff (!RST_B) !selected |=> !WRITE_PULSE && !READ_PULSE;
	endproperty
	a_no_pulse_unselected: assert property (p_no_pulse_unselected) else $error("pulse while deselected"); // see R4
	property p_addr_held;
		@(posedge SYS_CLK) disable iff (!RST_B) !(selected && wr_fall && s_cmd) |=> $stable(REG_ADDR);
	endproperty
	a_addr_held: assert property (p_addr_held) else $error("address moved without address phase"); // see R10
	property p_wide_addr;
		@(posedge SYS_CLK) disable iff (!RST_B) selected && wr_fall && s_cmd && wide
			|=> REG_ADDR[A16_LSB-1:0] == A16_PAD && BYTE_LANE_ENABLE == $past(s_bus[BE_LSB +: BE_W]);
	endproperty
	a_wide_addr: assert property (p_wide_addr) else $error("wide address phase decode wrong"); // see R2
	property p_narrow_addr;
		@(posedge SYS_CLK) disable iff (!RST_B) selected && wr_fall && s_cmd && !wide
			|=> REG_ADDR == $past(s_bus[ADDR_W-1:0]);
	endproperty
	a_narrow_addr: assert property (p_narrow_addr) else $error("narrow address phase decode wrong"); // see R3
	property p_rom_sel;
		@(posedge SYS_CLK) disable iff (!RST_B) ROM_ACCESS |=> CONFIG_ROM_SELECT;
	endproperty
	a_rom_sel: assert property (p_rom_sel) else $error("rom select not driven"); // see R6
	property p_data_write;
		@(posedge SYS_CLK) disable iff (!RST_B) selected && wr_fall && !s_cmd
			|=> WRITE_PULSE ##1 !WRITE_PULSE;
	endproperty
	a_data_write: assert property (p_data_write) else $error("write pulse wrong"); // see R1
	property p_read_pulse;
		@(posedge SYS_CLK) disable iff (!RST_B) READ_PULSE |-> $past(rd_fall) && !$past(s_cmd);
	endproperty
	a_read_pulse: assert property (p_read_pulse) else $error("read pulse without read strobe"); // see R9
	property p_be_narrow;
		@(posedge SYS_CLK) disable iff (!RST_B) selected && wr_fall && s_cmd && !wide |=> BYTE_LANE_ENABLE == BE_RST;
	endproperty
	a_be_narrow: assert property (p_be_narrow) else $error("byte enables set in narrow mode"); // see R7
	property p_strap_fixed;
		@(posedge SYS_CLK) disable iff (!RST_B) strap_done |=> $stable(wide);
	endproperty
	a_strap_fixed: assert property (p_strap_fixed) else $error("width changed after strap capture"); // see R8

	// ------------------------------------------------------------
	// checks, data lanes and line drive
	// ------------------------------------------------------------
	property p_oe_read;
		@(posedge SYS_CLK) disable iff (!RST_B) SHARED_BUS_LINES_OE
			|-> $past(selected) && !$past(s_cmd) && !$past(s_rd_low);
	endproperty
	a_oe_read: assert property (p_oe_read) else $error("lines driven outside a selected read"); // see R4
	property p_read_lanes;
		@(posedge SYS_CLK) disable iff (!RST_B) selected && rd_fall && !s_cmd
			|=> READ_PULSE && SHARED_BUS_LINES_OUT[BYTE_W-1:0] == $past(READ_DATA[BYTE_W-1:0])
			&& SHARED_BUS_LINES_OUT[BUS_W-1:BYTE_W] == (wide ? $past(READ_DATA[BUS_W-1:BYTE_W]) : HI_ZERO);
	endproperty
	a_read_lanes: assert property (p_read_lanes) else $error("read data lanes wrong"); // see R1
	property p_narrow_write;
		@(posedge SYS_CLK) disable iff (!RST_B) selected && wr_fall && !s_cmd && !wide
			|=> WRITE_DATA == {HI_ZERO, $past(s_bus[BYTE_W-1:0])};
	endproperty
	a_narrow_write: assert property (p_narrow_write) else $error("narrow write data wrong"); // see R1
	property p_out_held;
		@(posedge SYS_CLK) disable iff (!RST_B) !(selected && rd_fall && !s_cmd) |=> $stable(SHARED_BUS_LINES_OUT);
	endproperty
	a_out_held: assert property (p_out_held) else $error("read data moved without a read"); // see R1
endmodule : shared_bus_host_port
`default_nettype wire

// ===== verilog/shared_bus_pkg.sv
// constants for the shared-bus host port front end
// assumes one 250 MHz system clock and an asynchronous active-low reset
// Overview of operation
// R1: with the command-type input low an access is a data access on all sixteen lines (16-bit) or the low eight (8-bit).
// R2: in 16-bit mode with command high, lines 7..2 carry address bits 7..2, lines 15..12 the byte enables, lines 11..8 are ignored.
// R3: in 8-bit mode with command high, the low eight lines carry the full register address.
// R4: the port acts on the bus only while chip select is low and ignores it while chip select is high.
// R5: the host holds hardware reset low at least 10 ms after supply is stable, and the logic is reset meanwhile; the bench holds it low 2 or 4 cycles.
// R6: the configuration memory select output is driven whenever that memory is being accessed.
// R7: the four byte enables are active high, each selecting one byte lane of the addressed double word.
// R8: the width strap is sampled at reset, high or open selecting 16-bit and low selecting 8-bit.
// R9: the host asserts the active-low read strobe to perform a read cycle.
// R10: address and byte enables from an address phase apply to all following data phases until the next address phase.
package shared_bus_pkg;
	localparam int BUS_W      = 16;
	localparam int ADDR_W     = 8;
	localparam int BE_W       = 4;
	localparam int BE_LSB     = 12;
	localparam int A16_LSB    = 2;
	localparam int BYTE_W     = 8;
	localparam int STRAP_LAG  = 3;
	localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
	localparam logic [BE_W-1:0]   BE_RST   = 4'h0;
	localparam logic [BUS_W-1:0]  DATA_RST = 16'h0000;
	localparam logic [1:0]        A16_PAD  = 2'h0;
	localparam logic [7:0]        HI_ZERO  = 8'h00;
endpackage : shared_bus_pkg

// ===== verif/host_model.sv
// host side model: drives chip select, command, strobes and the shared lines
// assumes one clock shared with the port; the lines are released between cycles
`timescale 1ns/1ps
`default_nettype none
module host_model
	import shared_bus_pkg::*;
(
	// clock
	input  wire logic             clk,
	// host pins
	output logic                  cs_low,
	output logic                  cmd,
	output logic                  rd_low,
	output logic                  wr_low,
	output logic      [BUS_W-1:0] bus
);
	initial begin
		cs_low = 1'b1;
		cmd    = 1'b0;
		rd_low = 1'b1;
		wr_low = 1'b1;
		bus    = 16'h0000;
	end
	// one strobe cycle; bus settles 3 edges before the strobe falls
	task automatic cycle(input logic cs, input logic c, input logic rd, input logic [BUS_W-1:0] d);
		@(posedge clk);
		cs_low <= cs;
		cmd    <= c;
		bus    <= d;
		repeat (3) @(posedge clk);
		if (rd) rd_low <= 1'b0;
		else wr_low <= 1'b0;
		repeat (4) @(posedge clk);
		rd_low <= 1'b1;
		wr_low <= 1'b1;
		repeat (4) @(posedge clk);
		cs_low <= 1'b1;
		// released lines show the inverse, never a stale copy
		bus    <= ~d;
	endtask : cycle
endmodule : host_model
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the shared-bus host port
// assumes the host model drives the pins; core inputs come from here
`timescale 1ns/1ps
`default_nettype none
module tb
	import shared_bus_pkg::*;
;
	logic sys_clk = 1'b0, rst_b = 1'b0, strap = 1'b1, rom_access = 1'b0, oe, wp, rp, rom_sel, wide;
	logic cs_low, cmd, rd_low, wr_low;
	logic [BUS_W-1:0] host_bus, bus_out, rd_data = 16'h0000, wr_data;
	logic [ADDR_W-1:0] reg_addr;
	logic [BE_W-1:0] be;
	int n_mismatch = 0, n_checks = 0, n_wr = 0, n_rd = 0, n_oe = 0;
	initial forever #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (wp === 1'b1) n_wr <= n_wr + 1;
		if (rp === 1'b1) n_rd <= n_rd + 1;
		if (oe === 1'b1) n_oe <= n_oe + 1;
	end
	host_model host (.clk(sys_clk), .cs_low(cs_low), .cmd(cmd), .rd_low(rd_low), .wr_low(wr_low), .bus(host_bus));
	shared_bus_host_port DUT (
		.SYS_CLK(sys_clk), .RST_B(rst_b), .CHIP_SELECT_LOW(cs_low), .CMD_TYPE(cmd),
		.READ_STROBE_LOW(rd_low), .WRITE_STROBE_LOW(wr_low),
		.SHARED_BUS_LINES_IN(oe === 1'b1 ? bus_out : host_bus), .SHARED_BUS_LINES_OUT(bus_out),
		.SHARED_BUS_LINES_OE(oe), .BUS_WIDTH_STRAP_PIN(strap), .READ_DATA(rd_data), .ROM_ACCESS(rom_access),
		.CONFIG_ROM_SELECT(rom_sel), .REG_ADDR(reg_addr), .BYTE_LANE_ENABLE(be), .WIDE_MODE(wide),
		.WRITE_PULSE(wp), .READ_PULSE(rp), .WRITE_DATA(wr_data));
	task automatic chk(input logic [BUS_W-1:0] seen, input logic [BUS_W-1:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic do_reset(input int n);
		@(posedge sys_clk) rst_b <= 1'b0;
		repeat (n) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (6) @(posedge sys_clk);
	endtask : do_reset
	task automatic t_wide;
		chk(16'(wide), 16'h0001);
		host.cycle(1'b0, 1'b1, 1'b0, 16'hA9F7);
		chk(16'(reg_addr), 16'h00F4);
		chk(16'(be), 16'h000A);
		host.cycle(1'b0, 1'b0, 1'b0, 16'h1234);
		chk(wr_data, 16'h1234);
		host.cycle(1'b0, 1'b0, 1'b0, 16'hFEDC);
		chk(wr_data, 16'hFEDC);
		chk(16'(n_wr), 16'h0002);
		chk(16'(reg_addr), 16'h00F4);
		chk(16'(be), 16'h000A);
		$display("test wide done");
	endtask : t_wide
	task automatic t_read;
		rd_data <= 16'h5AC3;
		host.cycle(1'b0, 1'b0, 1'b1, 16'h0000);
		chk(bus_out, 16'h5AC3);
		// strobe low for 4 cycles, so the lines are driven for 4
		chk(16'(n_oe), 16'h0004);
		chk(16'(oe), 16'h0000);
		chk(16'(n_rd), 16'h0001);
		$display("test read done");
	endtask : t_read
	task automatic t_cs;
		host.cycle(1'b1, 1'b1, 1'b0, 16'h0F08);
		host.cycle(1'b1, 1'b0, 1'b0, 16'h7777);
		host.cycle(1'b1, 1'b0, 1'b1, 16'h0000);
		chk(16'(reg_addr), 16'h00F4);
		chk(wr_data, 16'hFEDC);
		chk(16'(n_wr), 16'h0002);
		chk(16'(n_rd), 16'h0001);
		chk(16'(n_oe), 16'h0004);
		$display("test chip select done");
	endtask : t_cs
	task automatic t_rom;
		@(posedge sys_clk) rom_access <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk(16'(rom_sel), 16'h0001);
		rom_access <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk(16'(rom_sel), 16'h0000);
		$display("test rom select done");
	endtask : t_rom
	task automatic t_narrow;
		strap <= 1'b0;
		do_reset(4);
		chk(16'(wide), 16'h0000);
		chk(16'(reg_addr), 16'h0000);
		host.cycle(1'b0, 1'b1, 1'b0, 16'h00B7);
		chk(16'(reg_addr), 16'h00B7);
		chk(16'(be), 16'h0000);
		host.cycle(1'b0, 1'b0, 1'b0, 16'h0042);
		chk(wr_data, 16'h0042);
		chk(16'(n_wr), 16'h0003);
		// upper core lane must not reach the lines in 8-bit mode
		rd_data <= 16'hC35A;
		host.cycle(1'b0, 1'b0, 1'b1, 16'h0000);
		chk(bus_out, 16'h005A);
		chk(16'(n_rd), 16'h0002);
		chk(16'(n_oe), 16'h0008);
		chk(16'(reg_addr), 16'h00B7);
		$display("test narrow done");
	endtask : t_narrow
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : conclude
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (6) @(posedge sys_clk);
		t_wide();
		t_read();
		t_cs();
		t_rom();
		t_narrow();
		conclude();
	end
	// about 150 cycles expected; generous margin
	initial begin
		#4000;
		n_mismatch++;
		conclude();
	end
endmodule : tb
`default_nettype wire
